// File: src/sram_host_pkg.sv
/*
 * Constants for the byte-lane static memory host: widths, timing, states.
 * Assumes a 100 MHz system clock driving the host.
 */
package sram_host_pkg;

    localparam int ADDR_W = 15;
    localparam int DATA_W = 16;
    localparam int LANE_W = 8;

    localparam int CLK_PERIOD_NS = 10;

    // Timing figures as printed
    localparam int T_RC_NS     = 10;
    localparam int T_AA_NS     = 10;
    localparam int T_WC_NS     = 10;
    localparam int T_PWE_NS    = 7;
    localparam int T_SD_NS     = 5;
    localparam int T_HZOE_NS   = 5;
    localparam int T_POWER_US  = 100;

    // Cycle counts, least times rounded up, one cycle more for reads
    localparam int RD_CYC = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int WR_CYC = ((T_WC_NS > T_PWE_NS ? T_WC_NS : T_PWE_NS) + T_HZOE_NS
                             + T_SD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWER_CYC = (T_POWER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int CNT_W  = 4;
    localparam int PWR_W  = 14;

    localparam logic [CNT_W-1:0] RD_CNT = CNT_W'(RD_CYC);
    localparam logic [CNT_W-1:0] WR_CNT = CNT_W'(WR_CYC);

    typedef enum logic [2:0] {
        ST_POWER = 3'h0,
        ST_IDLE  = 3'h1,
        ST_READ  = 3'h2,
        ST_WRITE = 3'h3,
        ST_GAP   = 3'h4
    } host_state_t;

endpackage : sram_host_pkg

// File: src/sram_power_wait.sv
/*
 * Power-up wait counter: signals ready once the supply settle time passed.
 * Assumes reset is released when supply reaches nominal level.
 */
`timescale 1ns/10ps
module sram_power_wait #(
    parameter int unsigned WAIT_CYC = sram_host_pkg::POWER_CYC
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    // Status
    output logic      pwr_ready_q
);
    import sram_host_pkg::*;

    logic [PWR_W-1:0] pwr_cnt_q;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pwr_cnt_q   <= '0;
            pwr_ready_q <= 1'b0;
        end else if (!pwr_ready_q) begin
            if (pwr_cnt_q >= PWR_W'(WAIT_CYC - 1)) begin
                pwr_ready_q <= 1'b1;
            end else begin
                pwr_cnt_q <= pwr_cnt_q + 1'b1;
            end
        end
    end

endmodule : sram_power_wait

// File: src/sram_host.sv
/*
 * Host controller for a 32K x 16 asynchronous SRAM with byte lanes.
 * Assumes the memory sits directly on the pins and the board resolves
 * the data wire from data_oe.
 */
// Operation
// - Write only during select, strobe, lane overlap
// - Reads spaced 10ns, data valid 10ns
// - Write cycle 10ns, strobe 7ns
// - Strobe-ended writes add float plus setup
// - No access before 100us power settle
// - Strobe high throughout every read
// - Address valid before select falls
`timescale 1ns/10ps
module sram_host #(
    parameter int unsigned POWER_WAIT = sram_host_pkg::POWER_CYC
) (
    // Clock and reset
    input  wire logic                              sys_clk,
    input  wire logic                              sys_rst,
    // User request
    input  wire logic                              req_valid,
    input  wire logic                              req_write,
    input  wire logic [sram_host_pkg::ADDR_W-1:0]  req_addr,
    input  wire logic [sram_host_pkg::DATA_W-1:0]  req_wdata,
    input  wire logic [1:0]                        req_lanes,
    output logic                                   req_ready,
    // User answer
    output logic                                   rsp_valid,
    output logic [sram_host_pkg::DATA_W-1:0]       rsp_rdata,
    // Memory pins
    output logic                                   chip_sel_n,
    output logic                                   out_en_n,
    output logic                                   write_n,
    output logic                                   lower_byte_sel_n,
    output logic                                   upper_byte_sel_n,
    output logic [sram_host_pkg::ADDR_W-1:0]       mem_addr,
    output logic [sram_host_pkg::DATA_W-1:0]       data_out,
    output logic                                   data_oe,
    input  wire logic [sram_host_pkg::DATA_W-1:0]  data_in
);
    import sram_host_pkg::*;

    host_state_t             state_q;
    logic [CNT_W-1:0]        cnt_q;
    logic [DATA_W-1:0]       din_meta_q;
    logic [DATA_W-1:0]       din_sync_q;
    logic                    pwr_ready;
    logic [1:0]              lanes_q;

    // ****************************************
    // Power settle wait
    // ****************************************
    sram_power_wait #(
        .WAIT_CYC    (POWER_WAIT)
    ) u_power (
        .sys_clk     (sys_clk),
        .sys_rst     (sys_rst),
        .pwr_ready_q (pwr_ready)
    );

    // ****************************************
    // Data input synchroniser
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            din_meta_q <= '0;
            din_sync_q <= '0;
        end else begin
            din_meta_q <= data_in;
            din_sync_q <= din_meta_q;
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q <= ST_POWER;
            cnt_q   <= '0;
        end else begin
            case (state_q)
                ST_POWER: begin
                    if (pwr_ready) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (req_valid && req_ready) begin
                        state_q <= req_write ? ST_WRITE : ST_READ;
                        cnt_q   <= '0;
                    end
                end
                ST_READ: begin
                    // Two extra cycles cover the input synchroniser
                    if (cnt_q == RD_CNT + CNT_W'(2)) begin
                        state_q <= ST_GAP;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                ST_WRITE: begin
                    if (cnt_q == WR_CNT - 1'b1) begin
                        state_q <= ST_GAP;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                ST_GAP: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Request handshake
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            req_ready <= 1'b0;
        end else begin
            req_ready <= (state_q == ST_IDLE && !(req_valid && req_ready))
                         || (state_q == ST_GAP);
        end
    end

    // ****************************************
    // Address, lanes and write data
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mem_addr <= '0;
            data_out <= '0;
            lanes_q  <= 2'h3;
        end else if (state_q == ST_IDLE && req_valid && req_ready) begin
            mem_addr <= req_addr;
            data_out <= req_wdata;
            lanes_q  <= ~req_lanes;
        end
    end

    // ****************************************
    // Memory control pins
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            chip_sel_n       <= 1'b1;
            out_en_n         <= 1'b1;
            write_n          <= 1'b1;
            lower_byte_sel_n <= 1'b1;
            upper_byte_sel_n <= 1'b1;
            data_oe          <= 1'b0;
        end else begin
            // Strobes assert one cycle after address is placed
            chip_sel_n       <= !(state_q == ST_READ || state_q == ST_WRITE);
            out_en_n         <= !(state_q == ST_READ);
            // Strobe rises one cycle before deselect, lanes held to end
            write_n          <= !(state_q == ST_WRITE && cnt_q != WR_CNT - 1'b1
                                  && lanes_q != 2'h3);
            lower_byte_sel_n <= (state_q == ST_READ || state_q == ST_WRITE)
                                ? lanes_q[0] : 1'b1;
            upper_byte_sel_n <= (state_q == ST_READ || state_q == ST_WRITE)
                                ? lanes_q[1] : 1'b1;
            data_oe          <= (state_q == ST_WRITE);
        end
    end

    // ****************************************
    // Read answer
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            rsp_valid <= 1'b0;
            if (state_q == ST_READ && cnt_q == RD_CNT + CNT_W'(2)) begin
                rsp_valid <= 1'b1;
                rsp_rdata[LANE_W-1:0]      <= lanes_q[0] ? '0 : din_sync_q[LANE_W-1:0];
                rsp_rdata[DATA_W-1:LANE_W] <= lanes_q[1] ? '0 : din_sync_q[DATA_W-1:LANE_W];
            end
        end
    end

endmodule : sram_host

// File: dv/sram_host_sva.sv
/* Pin protocol checker for the memory host.
   Assumes binding into every sram_host instance. */
`timescale 1ns/10ps
module sram_host_sva #(
    parameter int unsigned POWER_WAIT = 4
) (
    input wire logic                             sys_clk,
    input wire logic                             sys_rst,
    input wire logic                             rsp_valid,
    input wire logic                             chip_sel_n,
    input wire logic                             out_en_n,
    input wire logic                             write_n,
    input wire logic                             lower_byte_sel_n,
    input wire logic                             upper_byte_sel_n,
    input wire logic [sram_host_pkg::ADDR_W-1:0] mem_addr,
    input wire logic [sram_host_pkg::DATA_W-1:0] data_out,
    input wire logic                             data_oe
);
    import sram_host_pkg::*;
    logic [15:0] up_q;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            up_q <= '0;
        end else if (up_q < 16'hFFFF) begin
            up_q <= up_q + 16'h1;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    a_no_early_access: assert property (up_q < POWER_WAIT |-> chip_sel_n)
        else $error("select during power wait");
    a_strobe_high_read: assert property (!out_en_n |-> write_n)
        else $error("strobe low in read");
    a_write_overlap: assert property (!write_n |-> !chip_sel_n && data_oe
        && !(lower_byte_sel_n && upper_byte_sel_n)) else $error("bad write overlap");
    a_write_data_held: assert property ($fell(write_n) |=> write_n && !chip_sel_n
        && $stable(data_out) && $stable(mem_addr)) else $error("write cycle short");
    a_float_before_drive: assert property (data_oe |-> out_en_n)
        else $error("bus driven with outputs on");
    a_addr_before_sel: assert property ($fell(chip_sel_n) |-> $stable(mem_addr))
        else $error("address moved at select");
    a_read_held: assert property ($fell(out_en_n) |=> !out_en_n && $stable(mem_addr))
        else $error("read cycle short");
    a_read_answer: assert property ($fell(out_en_n) |-> ##4 rsp_valid)
        else $error("read answer late");
    cover property ($rose(write_n));
    cover property (rsp_valid);
    cover property ($fell(out_en_n) && upper_byte_sel_n);
endmodule : sram_host_sva
bind sram_host sram_host_sva #(.POWER_WAIT(POWER_WAIT)) sva_u (
    .sys_clk          (sys_clk),
    .sys_rst          (sys_rst),
    .rsp_valid        (rsp_valid),
    .chip_sel_n       (chip_sel_n),
    .out_en_n         (out_en_n),
    .write_n          (write_n),
    .lower_byte_sel_n (lower_byte_sel_n),
    .upper_byte_sel_n (upper_byte_sel_n),
    .mem_addr         (mem_addr),
    .data_out         (data_out),
    .data_oe          (data_oe)
);

// File: dv/sram_lane_model.sv
/* Behavioural byte-lane static memory on the host pins.
   Resolves the data wire itself from data_out through data_oe. */
`timescale 1ns/10ps
module sram_lane_model #(
    parameter int RD_DLY = 3
) (
    input wire logic                             chip_sel_n,
    input wire logic                             out_en_n,
    input wire logic                             write_n,
    input wire logic                             lower_byte_sel_n,
    input wire logic                             upper_byte_sel_n,
    input wire logic [sram_host_pkg::ADDR_W-1:0] mem_addr,
    input wire logic [sram_host_pkg::DATA_W-1:0] data_out,
    input wire logic                             data_oe,
    output logic     [sram_host_pkg::DATA_W-1:0] data_in
);
    import sram_host_pkg::*;
    logic [DATA_W-1:0] mem_q [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] rd_q = 16'h5A5A;
    logic [1:0]        sel_n;
    logic [1:0]        wr_on;
    logic [1:0]        lane_on;
    logic              rd_en;
    assign sel_n   = {upper_byte_sel_n, lower_byte_sel_n};
    assign rd_en   = !chip_sel_n && !out_en_n && write_n;
    assign wr_on   = {2{!chip_sel_n && !write_n}} & ~sel_n;
    assign lane_on = {2{rd_en}} & ~sel_n;
    // Enabled lanes take the bus while the write overlap lasts
    always @(wr_on or mem_addr or data_out or data_oe) begin
        for (int g = 0; g < 2; g++) begin
            if (wr_on[g]) begin
                mem_q[mem_addr][g*LANE_W +: LANE_W] = data_oe ? data_out[g*LANE_W +: LANE_W]
                                                              : ~rd_q[g*LANE_W +: LANE_W];
            end
        end
    end
    // Enabled read lanes fetch the addressed word
    always @(lane_on or mem_addr) begin
        for (int g = 0; g < 2; g++) begin
            if (lane_on[g]) begin
                rd_q[g*LANE_W +: LANE_W] = mem_q[mem_addr][g*LANE_W +: LANE_W];
            end
        end
    end
    // Floated lane shows a changed value, never stale data
    assign #(RD_DLY) data_in = rd_q ^ ~{{LANE_W{lane_on[1]}}, {LANE_W{lane_on[0]}}};
endmodule : sram_lane_model

// File: dv/tb_top.sv
/* Bench for the memory host with the lane model on its pins.
   Assumes package, checker and model are compiled first. */
`timescale 1ns/10ps
module tb_top;
    import sram_host_pkg::*;
    localparam int unsigned PW = 4;
    logic              sys_clk = 1'b0;
    logic              sys_rst = 1'b1;
    logic              req_valid = 1'b0;
    logic              req_write = 1'b0;
    logic [ADDR_W-1:0] req_addr = '0;
    logic [DATA_W-1:0] req_wdata = '0;
    logic [1:0]        req_lanes = '0;
    logic [DATA_W-1:0] rsp_rdata, data_out, data_in, q;
    logic [ADDR_W-1:0] mem_addr;
    logic              req_ready, rsp_valid, chip_sel_n, out_en_n, write_n, data_oe;
    logic              lower_byte_sel_n, upper_byte_sel_n;
    int                n_mismatch = 0;
    int                checks = 0;
    sram_host #(.POWER_WAIT(PW)) dut_u (.sys_clk, .sys_rst, .req_valid, .req_write,
        .req_addr, .req_wdata, .req_lanes, .req_ready, .rsp_valid, .rsp_rdata, .chip_sel_n,
        .out_en_n, .write_n, .lower_byte_sel_n, .upper_byte_sel_n, .mem_addr, .data_out,
        .data_oe, .data_in);
    sram_lane_model mem_u (.chip_sel_n, .out_en_n, .write_n, .lower_byte_sel_n,
        .upper_byte_sel_n, .mem_addr, .data_out, .data_oe, .data_in);
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic op(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      input logic [1:0] ln);
        int n;
        n = 0;
        req_valid <= 1'b1;
        req_write <= wr;
        req_addr <= a;
        req_wdata <= d;
        req_lanes <= ln;
        do begin
            @(negedge sys_clk);
            n++;
        end while (req_ready !== 1'b1 && n < 40);
        chk("req_ready", 16'h1, {15'h0, req_ready});
        @(posedge sys_clk);
        req_valid <= 1'b0;
        while (!wr && rsp_valid !== 1'b1 && n < 80) begin
            @(negedge sys_clk);
            n++;
        end
        if (!wr) begin
            chk("rsp_valid", 16'h1, {15'h0, rsp_valid});
        end
        q = rsp_rdata;
        @(posedge sys_clk);
    endtask : op
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [1:0] ln,
                      input logic [DATA_W-1:0] e);
        op(1'b0, a, '0, ln);
        chk("rsp_rdata", e, q);
    endtask : rd
    task automatic t_power_wait;
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 100) begin
            @(negedge sys_clk);
            chk("chip_sel_n", 16'h1, {15'h0, chip_sel_n});
            n++;
        end
        chk("wait_cycles", 16'h1, {15'h0, n >= PW});
        chk("req_ready", 16'h1, {15'h0, req_ready});
        @(posedge sys_clk);
    endtask : t_power_wait
    task automatic t_lanes;
        op(1'b1, 15'h7FFF, 16'h1234, 2'h3);
        rd(15'h7FFF, 2'h3, 16'h1234);
        op(1'b1, 15'h7FFF, 16'hABCD, 2'h1);
        rd(15'h7FFF, 2'h3, 16'h12CD);
        rd(15'h7FFF, 2'h2, 16'h1200);
        rd(15'h7FFF, 2'h1, 16'h00CD);
    endtask : t_lanes
    task automatic t_low_addr;
        op(1'b1, 15'h0000, 16'hBEEF, 2'h3);
        op(1'b1, 15'h0000, 16'h55AA, 2'h2);
        rd(15'h0000, 2'h3, 16'h55EF);
        op(1'b1, 15'h7FFF, 16'hFFFF, 2'h0);
        rd(15'h7FFF, 2'h3, 16'h12CD);
    endtask : t_low_addr
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_power_wait();
        t_lanes();
        t_low_addr();
        tally_and_finish();
    end
    initial begin
        repeat (3000) @(posedge sys_clk);
        n_mismatch++;
        tally_and_finish();
    end
endmodule : tb_top
